// ### hdl/kbc_host_pkg.sv
/*
 Constants shared by the keyboard controller host interface: host port
 addresses, status bit positions, reset values and the quasi-bidirectional
 drive time. Assumes a 25 MHz core clock.
*/
package kbc_host_pkg;
   localparam logic [7:0] DATA_PORT_ADDR   = 8'h60;
   localparam logic [7:0] CONTROL_PORT_ADDR = 8'h64;
   localparam int         HOST_ADDR_BIT2_POS = 2;
   localparam int         STAT_OBF_POS     = 0;
   localparam int         STAT_IBF_POS     = 1;
   localparam int         STAT_CD_POS      = 3;
   localparam logic [7:0] STATUS_RESET     = 8'h00;
   localparam logic [7:0] USER_BITS_MASK   = 8'hF4;
   localparam int         CLOCK_MHZ        = 25;
   localparam int         DRIVE_HIGH_NS    = 500;
   localparam int         DRIVE_HIGH_CYCLES =
      ((DRIVE_HIGH_NS * CLOCK_MHZ) / 1000 < 1) ? 1 : (DRIVE_HIGH_NS * CLOCK_MHZ) / 1000;
endpackage

// ### hdl/kbc_skid_buffer.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock, asynchronous active-high reset and a clock enable.
*/
module kbc_skid_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_r [2];
   logic             wr_ptr_r;
   logic             rd_ptr_r;
   logic [1:0]       count_r;
   logic             push;
   logic             pop;

   assign in_ready  = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end
endmodule

// ### hdl/kbc_quasi_pin.sv
/*
 One quasi-bidirectional port pin. A zero drives low; a one drives high for a
 short time, then releases to the external pull-up. Open-drain mode never
 drives high. Assumes one clock and a clock enable.
*/
module kbc_quasi_pin #(
   parameter int HIGH_CYCLES = kbc_host_pkg::DRIVE_HIGH_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic port_value,
   input  wire logic open_drain,
   output logic      pin_out,
   output logic      pin_oe
);
   logic [7:0] hold_r;
   logic       last_r;

   // A rising port value arms the high drive; it counts down to release.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_r <= 8'h00;
         last_r <= 1'b0;
      end else if (ce) begin
         last_r <= port_value;
         if (port_value && !last_r) begin
            hold_r <= 8'(HIGH_CYCLES);
         end else if (!port_value) begin
            hold_r <= 8'h00;
         end else if (hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
         end
      end
   end

   always_comb begin
      pin_out = port_value;
      if (!port_value) begin
         pin_oe = 1'b1; // see (RL16) (RL17)
      end else if (open_drain) begin
         pin_oe = 1'b0; // see (RL17)
      end else begin
         pin_oe = (hold_r != 8'h00) || (port_value && !last_r); // see (RL16)
      end
   end
endmodule

// ### hdl/kbc_host_interface.sv
/*
 Host interface of the embedded keyboard controller: two host port
 addresses, data and command input registers, output data register,
 status flags, keyboard and mouse interrupt gating, Gate A20 and three
 quasi-bidirectional port pins. The core side is a strobe port on the same
 clock; host strobes come from the bus decoder on the same clock as well.
 Pin inputs from outside pass two flip-flops.
*/
// Functional notes
// (RL1) Host write to 0x60 loads input data, clears C/D, sets input-full.
// (RL2) Host write to 0x64 loads input data, sets C/D, sets input-full.
// (RL3) Host read of 0x64 returns the status byte with the three flags.
// (RL4) Write data, command data and read data live in separate registers.
// (RL5) With gating on, host data read clears output-full and keyboard IRQ.
// (RL6) With gating off, firmware clears keyboard IRQ and aux output-full itself.
// (RL7) Core buffer write loads output data and sets output-full, status bit 0.
// (RL8) Status bit 3 marks command versus data, following host address bit 2.
// (RL9) Gating on with keyboard port bit one puts output-full on keyboard IRQ.
// (RL10) Gating on with keyboard port bit zero forces keyboard IRQ low.
// (RL11) Keyboard IRQ is low after reset.
// (RL12) Gating off, keyboard IRQ follows its port bit.
// (RL13) Gating on with mouse port bit one drives inverted input-full on mouse IRQ.
// (RL14) Gating off, mouse IRQ follows its port bit.
// (RL15) A port bit is brought out as Gate A20 or user output.
// (RL16) Quasi pins: zero drives low, one drives high briefly then releases.
// (RL17) Open drain: one tri-states, zero drives low, no active high.
// (RL18) Controller mode never makes these pins inputs or inverts them.
// (RL19) Core read of input data clears input-full and its core interrupt.
// (RL20) Status clears to zero on hardware reset.
// (RL21) Host status read leaves flags and IRQs unchanged.
module kbc_host_interface (
   input  wire logic       CLOCK,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic       HOST_WR,
   input  wire logic       HOST_RD,
   input  wire logic [7:0] HOST_ADDR,
   input  wire logic [7:0] HOST_WDATA,
   output logic      [7:0] HOST_RDATA,
   output logic            IN_VALID,
   input  wire logic       IN_READY,
   output logic      [7:0] IN_DATA,
   output logic            IN_IS_COMMAND,
   output logic            CORE_IBF_IRQ,
   input  wire logic       CORE_BUF_WR,
   input  wire logic [7:0] CORE_BUF_WDATA,
   output logic            CORE_BUF_READY,
   input  wire logic       CORE_STATUS_WR,
   input  wire logic [7:0] CORE_STATUS_WDATA,
   output logic      [7:0] CORE_STATUS,
   input  wire logic       CORE_EN_FLAGS,
   input  wire logic       CORE_OBF_CLEAR,
   input  wire logic       KEYBOARD_IRQ_OUT_PORT_BIT,
   input  wire logic       MOUSE_IRQ_OUT_PORT_BIT,
   input  wire logic       GATE_A20_PORT_BIT,
   input  wire logic [2:0] PORT_PIN_VALUE,
   input  wire logic       OPEN_DRAIN,
   input  wire logic [2:0] PORT_PIN_IN,
   output logic      [2:0] PORT_PIN_SYNC,
   output logic      [2:0] PORT_PIN_OUT,
   output logic      [2:0] PORT_PIN_OE,
   output logic            KEYBOARD_IRQ_OUT,
   output logic            MOUSE_IRQ_OUT,
   output logic            GATE_A20_OUT
);
   logic [7:0] host_data_write_r;
   logic [7:0] host_command_write_r;
   logic [7:0] host_data_read_r;
   logic       input_full_flag_r;
   logic       output_full_flag_r;
   logic       cmd_data_r;
   logic [7:0] user_bits_r;
   logic       flags_enabled_r;
   logic       keyboard_irq_out_r;
   logic       mouse_irq_out_r;
   logic       gate_a20_r;
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       host_data_wr;
   logic       host_cmd_wr;
   logic       host_data_rd;
   logic       core_take;
   logic       buf_in_valid;
   logic       buf_in_ready;
   logic       buf_out_valid;
   logic [7:0] buf_out_data;
   logic [7:0] status;

   assign host_data_wr = CE && HOST_WR && (HOST_ADDR == kbc_host_pkg::DATA_PORT_ADDR);
   assign host_cmd_wr  = CE && HOST_WR && (HOST_ADDR == kbc_host_pkg::CONTROL_PORT_ADDR);
   assign host_data_rd = CE && HOST_RD && (HOST_ADDR == kbc_host_pkg::DATA_PORT_ADDR);
   assign core_take    = CE && IN_VALID && IN_READY;

   // Separate holding registers; the shared address only picks which one loads.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         host_data_write_r    <= 8'h00;
         host_command_write_r <= 8'h00;
      end else begin
         if (host_data_wr) begin
            host_data_write_r <= HOST_WDATA; // see (RL1) (RL4)
         end
         if (host_cmd_wr) begin
            host_command_write_r <= HOST_WDATA; // see (RL2) (RL4)
         end
      end
   end

   // Input-full: a new host write wins over a core read in the same cycle.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         input_full_flag_r <= 1'b0; // see (RL20)
         cmd_data_r        <= 1'b0;
      end else if (CE) begin
         if (host_data_wr || host_cmd_wr) begin
            input_full_flag_r <= 1'b1; // see (RL1) (RL2)
            cmd_data_r <= HOST_ADDR[kbc_host_pkg::HOST_ADDR_BIT2_POS]; // see (RL8)
         end else if (core_take) begin
            input_full_flag_r <= 1'b0; // see (RL19)
         end
      end
   end

   assign IN_VALID      = input_full_flag_r;
   assign IN_DATA       = cmd_data_r ? host_command_write_r : host_data_write_r;
   assign IN_IS_COMMAND = cmd_data_r; // see (RL8)
   assign CORE_IBF_IRQ  = input_full_flag_r; // see (RL19)

   // Core writes queue in a two-entry buffer so a busy output register loses nothing.
   assign buf_in_valid   = CORE_BUF_WR;
   assign CORE_BUF_READY = buf_in_ready;

   kbc_skid_buffer #(
      .WIDTH(8)
   ) out_buffer (
      .clk      (CLOCK),
      .rst      (RST),
      .ce       (CE),
      .in_valid (buf_in_valid),
      .in_ready (buf_in_ready),
      .in_data  (CORE_BUF_WDATA),
      .out_valid(buf_out_valid),
      .out_ready(!output_full_flag_r),
      .out_data (buf_out_data)
   );

   // Output-full: a load from the buffer wins over a clear in the same cycle.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         output_full_flag_r <= 1'b0; // see (RL20)
         host_data_read_r   <= 8'h00;
      end else if (CE) begin
         if (buf_out_valid && !output_full_flag_r) begin
            host_data_read_r   <= buf_out_data; // see (RL7) (RL4)
            output_full_flag_r <= 1'b1; // see (RL7)
         end else if (host_data_rd && flags_enabled_r) begin
            output_full_flag_r <= 1'b0; // see (RL5)
         end else if (CORE_OBF_CLEAR) begin
            output_full_flag_r <= 1'b0; // see (RL6)
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         user_bits_r     <= kbc_host_pkg::STATUS_RESET; // see (RL20)
         flags_enabled_r <= 1'b0;
      end else if (CE) begin
         if (CORE_STATUS_WR) begin
            user_bits_r <= CORE_STATUS_WDATA & kbc_host_pkg::USER_BITS_MASK;
         end
         if (CORE_EN_FLAGS) begin
            flags_enabled_r <= 1'b1;
         end
      end
   end

   always_comb begin
      status = user_bits_r;
      status[kbc_host_pkg::STAT_OBF_POS] = output_full_flag_r; // see (RL7)
      status[kbc_host_pkg::STAT_IBF_POS] = input_full_flag_r;
      status[kbc_host_pkg::STAT_CD_POS]  = cmd_data_r; // see (RL8)
   end

   assign CORE_STATUS = status;

   // Reading status has no side effects; only the data port read clears a flag.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         HOST_RDATA <= 8'h00;
      end else if (CE && HOST_RD) begin
         if (HOST_ADDR == kbc_host_pkg::CONTROL_PORT_ADDR) begin
            HOST_RDATA <= status; // see (RL3) (RL21)
         end else if (HOST_ADDR == kbc_host_pkg::DATA_PORT_ADDR) begin
            HOST_RDATA <= host_data_read_r;
         end else begin
            HOST_RDATA <= 8'h00;
         end
      end
   end

   // Interrupt outputs are registered so they never glitch toward the host.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         keyboard_irq_out_r     <= 1'b0; // see (RL11)
         mouse_irq_out_r     <= 1'b0;
         gate_a20_r <= 1'b0;
      end else if (CE) begin
         if (flags_enabled_r) begin
            keyboard_irq_out_r <= KEYBOARD_IRQ_OUT_PORT_BIT && output_full_flag_r; // see (RL9) (RL10)
            mouse_irq_out_r <= MOUSE_IRQ_OUT_PORT_BIT && !input_full_flag_r; // see (RL13)
         end else begin
            keyboard_irq_out_r <= KEYBOARD_IRQ_OUT_PORT_BIT; // see (RL12) (RL6)
            mouse_irq_out_r <= MOUSE_IRQ_OUT_PORT_BIT; // see (RL14)
         end
         gate_a20_r <= GATE_A20_PORT_BIT; // see (RL15)
      end
   end

   assign KEYBOARD_IRQ_OUT = keyboard_irq_out_r;
   assign MOUSE_IRQ_OUT    = mouse_irq_out_r;
   assign GATE_A20_OUT     = gate_a20_r;

   // Pin levels are only observed; they never turn the pins into inputs.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end else if (CE) begin
         pin_meta_r <= PORT_PIN_IN;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign PORT_PIN_SYNC = pin_sync_r;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_pin
         kbc_quasi_pin #(
            .HIGH_CYCLES(kbc_host_pkg::DRIVE_HIGH_CYCLES)
         ) pin (
            .clk       (CLOCK),
            .rst       (RST),
            .ce        (CE),
            .port_value(PORT_PIN_VALUE[i]), // see (RL18)
            .open_drain(OPEN_DRAIN),
            .pin_out   (PORT_PIN_OUT[i]),
            .pin_oe    (PORT_PIN_OE[i])
         );
      end
   endgenerate
endmodule

// ### bench/kbc_host_chk.sv
/*
 Concurrent checks on the ports of the keyboard controller host interface.
 Assumes one clock and RST asynchronous active high. CE may drop for a few
 cycles; the write and core-take checks name CE, the IRQ and drive-time checks do not.
*/
module kbc_host_chk (
   input wire logic       CLOCK,
   input wire logic       RST,
   input wire logic       CE,
   input wire logic       HOST_WR,
   input wire logic [7:0] HOST_ADDR,
   input wire logic [7:0] HOST_WDATA,
   input wire logic       IN_VALID,
   input wire logic       IN_READY,
   input wire logic [7:0] IN_DATA,
   input wire logic       IN_IS_COMMAND,
   input wire logic       CORE_IBF_IRQ,
   input wire logic [7:0] CORE_STATUS,
   input wire logic       KEYBOARD_IRQ_OUT_PORT_BIT,
   input wire logic       MOUSE_IRQ_OUT_PORT_BIT,
   input wire logic [2:0] PORT_PIN_VALUE,
   input wire logic       OPEN_DRAIN,
   input wire logic [2:0] PORT_PIN_OUT,
   input wire logic [2:0] PORT_PIN_OE,
   input wire logic       KEYBOARD_IRQ_OUT,
   input wire logic       MOUSE_IRQ_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   sequence s_rise0;
      $rose(PORT_PIN_VALUE[0]) && !OPEN_DRAIN;
   endsequence
   // Fourteen cycles: the rising cycle, twelve more driven, then the release.
   sequence s_hold0;
      (PORT_PIN_VALUE[0] && !OPEN_DRAIN)[*7] ##1 (PORT_PIN_VALUE[0] && !OPEN_DRAIN)[*7];
   endsequence
   data_write_a: assert property (CE && HOST_WR && HOST_ADDR == 8'h60
      |=> IN_VALID && !IN_IS_COMMAND && IN_DATA == $past(HOST_WDATA))
      else $error("Data write gave wrong flags.");
   cmd_write_a: assert property (CE && HOST_WR && HOST_ADDR == 8'h64
      |=> IN_VALID && IN_IS_COMMAND && IN_DATA == $past(HOST_WDATA))
      else $error("Command write gave wrong flags.");
   core_take_a: assert property (CE && IN_VALID && IN_READY && !HOST_WR
      |=> !IN_VALID && !CORE_IBF_IRQ)
      else $error("Core read left input full.");
   status_bits_a: assert property (CORE_STATUS[1] == IN_VALID &&
      CORE_STATUS[3] == IN_IS_COMMAND)
      else $error("Status flags disagree.");
   reset_clear_a: assert property ($fell(RST) |->
      !KEYBOARD_IRQ_OUT && !MOUSE_IRQ_OUT && CORE_STATUS == 8'h00)
      else $error("State not clear after reset.");
   keyboard_irq_out_low_a: assert property (!KEYBOARD_IRQ_OUT_PORT_BIT ##1 !KEYBOARD_IRQ_OUT_PORT_BIT
      |-> !KEYBOARD_IRQ_OUT)
      else $error("Keyboard IRQ high with port bit low.");
   mouse_irq_out_low_a: assert property (!MOUSE_IRQ_OUT_PORT_BIT ##1 !MOUSE_IRQ_OUT_PORT_BIT
      |-> !MOUSE_IRQ_OUT)
      else $error("Mouse IRQ high with port bit low.");
   pin_low_a: assert property ((~PORT_PIN_VALUE & ~PORT_PIN_OE) == 3'h0 &&
      PORT_PIN_OUT == PORT_PIN_VALUE)
      else $error("Pin not driven to its value.");
   open_drain_a: assert property (OPEN_DRAIN
      |-> (PORT_PIN_OE & PORT_PIN_VALUE) == 3'h0)
      else $error("Open drain pin driven high.");
   drive_time_a: assert property (s_rise0 ##0 s_hold0
      |-> !PORT_PIN_OE[0] && $past(PORT_PIN_OE[0]))
      else $error("High drive time wrong.");
endmodule

bind kbc_host_interface kbc_host_chk u_kbc_host_chk (.*);

// ### bench/host_model.sv
/*
 Host side model: one-cycle I/O write and read strobes on the bus decoder
 port. Assumes the design's clock; tasks are called from the testbench.
*/
module host_model (
   input  wire logic       CLOCK,
   output logic            HOST_WR,
   output logic            HOST_RD,
   output logic      [7:0] HOST_ADDR,
   output logic      [7:0] HOST_WDATA,
   input  wire logic [7:0] HOST_RDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      HOST_WR = 1'b0;
      HOST_RD = 1'b0;
      HOST_ADDR = 8'h00;
      HOST_WDATA = 8'h00;
   end
   // A released bus shows the inverse so a stale address is never reused.
   task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge CLOCK);
      HOST_ADDR <= addr;
      HOST_WDATA <= data;
      HOST_WR <= 1'b1;
      @(posedge CLOCK);
      HOST_WR <= 1'b0;
      HOST_ADDR <= ~addr;
      HOST_WDATA <= ~data;
   endtask
   task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge CLOCK);
      HOST_ADDR <= addr;
      HOST_RD <= 1'b1;
      @(posedge CLOCK);
      HOST_RD <= 1'b0;
      HOST_ADDR <= ~addr;
      @(posedge CLOCK);
      data = HOST_RDATA;
   endtask
endmodule

// ### bench/testbench.sv
/*
 Self-checking testbench for the host interface with the host model.
 Assumes a 25 MHz clock and the core side driven directly from here.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       CLOCK, RST, CE, IN_READY, CORE_BUF_WR, CORE_STATUS_WR, CORE_EN_FLAGS;
   logic       CORE_OBF_CLEAR, KEYBOARD_IRQ_OUT_PORT_BIT, MOUSE_IRQ_OUT_PORT_BIT, GATE_A20_PORT_BIT, OPEN_DRAIN;
   logic       HOST_WR, HOST_RD, IN_VALID, IN_IS_COMMAND, CORE_IBF_IRQ, CORE_BUF_READY;
   logic       KEYBOARD_IRQ_OUT, MOUSE_IRQ_OUT, GATE_A20_OUT;
   logic [7:0] HOST_ADDR, HOST_WDATA, HOST_RDATA, IN_DATA, CORE_BUF_WDATA, rd;
   logic [7:0] CORE_STATUS_WDATA, CORE_STATUS;
   logic [2:0] PORT_PIN_VALUE, PORT_PIN_IN, PORT_PIN_SYNC, PORT_PIN_OUT, PORT_PIN_OE;
   int         error_cnt, num_checks;
   kbc_host_interface u_kbc_host_interface (.*);
   host_model u_host_model (.*);
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK);
   endtask
   task automatic take;
      @(posedge CLOCK);
      IN_READY <= 1'b1;
      @(posedge CLOCK);
      IN_READY <= 1'b0;
   endtask
   task automatic core_write(input logic [7:0] d);
      @(posedge CLOCK);
      CORE_BUF_WR <= 1'b1;
      CORE_BUF_WDATA <= d;
      do @(posedge CLOCK); while (!CORE_BUF_READY);
      CORE_BUF_WR <= 1'b0;
   endtask
   task automatic t_reset;
      check(CORE_STATUS, 8'h00);
      check(8'(KEYBOARD_IRQ_OUT), 8'h00);
      u_host_model.io_read(8'h64, rd);
      check(rd, 8'h00);
      u_host_model.io_read(8'h70, rd);
      check(rd, 8'h00);
      @(posedge CLOCK);
      CORE_STATUS_WR <= 1'b1;
      CORE_STATUS_WDATA <= 8'hFF;
      @(posedge CLOCK);
      CORE_STATUS_WR <= 1'b0;
      tick(1);
      check(CORE_STATUS, 8'hF4);
      $display("Test reset done");
   endtask
   task automatic t_host;
      u_host_model.io_write(8'h60, 8'hA5);
      tick(1);
      check(CORE_STATUS, 8'hF6);
      check(IN_DATA, 8'hA5);
      take;
      tick(1);
      check(8'({IN_VALID, CORE_IBF_IRQ}), 8'h00);
      u_host_model.io_write(8'h61, 8'h11);
      tick(1);
      check(CORE_STATUS, 8'hF4);
      u_host_model.io_write(8'h64, 8'h3C);
      tick(1);
      check(CORE_STATUS, 8'hFE);
      check(IN_DATA, 8'h3C);
      $display("Test host writes done");
   endtask
   task automatic t_nogate;
      core_write(8'h5A);
      tick(3);
      check(CORE_STATUS, 8'hFF);
      check(8'(KEYBOARD_IRQ_OUT), 8'h00);
      u_host_model.io_read(8'h60, rd);
      check(rd, 8'h5A);
      check(IN_DATA, 8'h3C);
      tick(2);
      check(CORE_STATUS, 8'hFF);
      @(posedge CLOCK);
      CORE_OBF_CLEAR <= 1'b1;
      @(posedge CLOCK);
      CORE_OBF_CLEAR <= 1'b0;
      KEYBOARD_IRQ_OUT_PORT_BIT <= 1'b1;
      MOUSE_IRQ_OUT_PORT_BIT <= 1'b1;
      tick(3);
      check(CORE_STATUS, 8'hFE);
      check(8'({KEYBOARD_IRQ_OUT, MOUSE_IRQ_OUT}), 8'h03);
      $display("Test without gating done");
   endtask
   task automatic t_gate;
      @(posedge CLOCK);
      CORE_EN_FLAGS <= 1'b1;
      @(posedge CLOCK);
      CORE_EN_FLAGS <= 1'b0;
      tick(2);
      check(8'(MOUSE_IRQ_OUT), 8'h00);
      take;
      tick(2);
      check(8'(MOUSE_IRQ_OUT), 8'h01);
      core_write(8'h77);
      core_write(8'h88);
      core_write(8'h99);
      tick(2);
      check(8'(CORE_BUF_READY), 8'h00);
      check(8'(KEYBOARD_IRQ_OUT), 8'h01);
      u_host_model.io_read(8'h64, rd);
      check(rd, 8'hFD);
      check(CORE_STATUS, 8'hFD);
      check(8'(KEYBOARD_IRQ_OUT), 8'h01);
      @(posedge CLOCK);
      KEYBOARD_IRQ_OUT_PORT_BIT <= 1'b0;
      tick(2);
      check(8'(KEYBOARD_IRQ_OUT), 8'h00);
      KEYBOARD_IRQ_OUT_PORT_BIT <= 1'b1;
      u_host_model.io_read(8'h60, rd);
      check(rd, 8'h77);
      tick(4);
      u_host_model.io_read(8'h60, rd);
      check(rd, 8'h88);
      tick(4);
      u_host_model.io_read(8'h60, rd);
      check(rd, 8'h99);
      tick(3);
      check(CORE_STATUS, 8'hFC);
      check(8'(KEYBOARD_IRQ_OUT), 8'h00);
      $display("Test gating done");
   endtask
   task automatic t_pins;
      @(posedge CLOCK);
      PORT_PIN_VALUE <= 3'h1;
      PORT_PIN_IN <= 3'h5;
      GATE_A20_PORT_BIT <= 1'b1;
      tick(3);
      check(8'(PORT_PIN_OE), 8'h07);
      check(8'(PORT_PIN_SYNC), 8'h05);
      check(8'(GATE_A20_OUT), 8'h01);
      tick(15);
      check(8'(PORT_PIN_OE), 8'h06);
      check(8'(PORT_PIN_OUT), 8'h01);
      OPEN_DRAIN <= 1'b1;
      PORT_PIN_VALUE <= 3'h2;
      tick(2);
      check(8'(PORT_PIN_OE), 8'h05);
      check(8'(PORT_PIN_OUT), 8'h02);
      $display("Test pins done");
   endtask
   // A frozen block must ignore host strobes; a second reset must clear live state.
   task automatic t_freeze;
      @(posedge CLOCK);
      CE <= 1'b0;
      u_host_model.io_write(8'h60, 8'h5A);
      u_host_model.io_read(8'h64, rd);
      check(rd, 8'h99);
      check(CORE_STATUS, 8'hFC);
      check(IN_DATA, 8'h3C);
      CE <= 1'b1;
      RST <= 1'b1;
      tick(2);
      check(CORE_STATUS, 8'h00);
      check(8'(KEYBOARD_IRQ_OUT), 8'h00);
      RST <= 1'b0;
      u_host_model.io_read(8'h60, rd);
      check(rd, 8'h00);
      $display("Test freeze and reset done");
   endtask
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // The tests need under two hundred cycles; the 5000-cycle limit leaves ample margin.
   initial begin
      #200000;
      error_cnt++;
      print_verdict;
   end
   initial begin
      {RST, CE} = 2'h3;
      {IN_READY, CORE_BUF_WR, CORE_STATUS_WR, CORE_EN_FLAGS, CORE_OBF_CLEAR} = 5'h00;
      {KEYBOARD_IRQ_OUT_PORT_BIT, MOUSE_IRQ_OUT_PORT_BIT, GATE_A20_PORT_BIT, OPEN_DRAIN} = 4'h0;
      {CORE_BUF_WDATA, CORE_STATUS_WDATA} = 16'h0000;
      {PORT_PIN_VALUE, PORT_PIN_IN} = 6'h00;
      error_cnt = 0;
      num_checks = 0;
      repeat (2) @(posedge CLOCK);
      RST <= 1'b0;
      t_reset;
      t_host;
      t_nogate;
      t_gate;
      t_pins;
      t_freeze;
      print_verdict;
   end
endmodule
